//--- logic/e1m_mode_decode.sv
`timescale 1ns/1ps
`include "e1m_consts.svh"
// Functional notes
// - hardware unipolar: codec pin picks HDB3/AMI
// - host mode: codec from register bit
// - host mode: flavour pin picks strobe style
// - hardware: jitter select places attenuator
// - mode pin picks hardware/parallel/serial
// - hardware: parallel port off, pins rule
// - serial host uses only serial pins
// - parallel: mux pin picks bus form
// - parallel non-muxed: monitor pins become address
// - low bits zero means no monitoring
// - bit 3 zero monitors receiver n
// - bit 3 one monitors transmitter n, none if n looped back
// - no marks long enough raises loss
// - enough transitions in window clears loss
// - power-up or soft reset restores defaults
module e1m_mode_decode
	import e1m_pkg::*;
#(
	parameter int NUM_CH        = `E1M_NUM_CH,
	parameter int RST_LONG_CYC  = `E1M_RST_LONG_CYC,
	parameter int RST_SHORT_CYC = `E1M_RST_SHORT_CYC,
	parameter int LOS_SET_CYC   = `E1M_LOS_SET_CYC,
	parameter int LOS_WIN_CYC   = `E1M_LOS_WIN_CYC,
	parameter int LOS_CLR_MARKS = `E1M_LOS_CLR_MARKS
) (
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	input  wire logic [1:0]        mode_tri_i,
	input  wire logic [1:0]        jitter_atten_position_select_i,
	input  wire logic              codec_select_i,
	input  wire logic              host_bus_flavour_select_i,
	input  wire logic              bus_mux_select_i,
	input  wire logic [4:0]        monitor_select_i,
	input  wire logic [NUM_CH-1:0] unipolar_bipolar_select_i,
	input  wire logic [NUM_CH-1:0] analog_loopback_i,
	input  wire logic              reg_codec_ami_i,
	input  wire logic [4:0]        reg_monitor_select_i,
	input  wire logic              soft_reset_register_wr_i,
	input  wire logic [NUM_CH-1:0] rx_mark_i,
	output logic [1:0]             ctl_mode_o,
	output logic                   parallel_port_en_o,
	output logic                   serial_port_en_o,
	output logic                   sep_strobe_style_o,
	output logic                   muxed_bus_o,
	output logic                   address_pins_en_o,
	output logic [NUM_CH-1:0]      codec_ami_o,
	output logic [1:0]             ja_position_o,
	output logic [1:0]             mon_kind_o,
	output logic [2:0]             mon_channel_o,
	output logic                   mon_blocked_o,
	output logic                   regs_reset_o,
	output logic [NUM_CH-1:0]      signal_loss_flag_o
);
	typedef struct packed {
		logic [1:0] mode_s1;
		logic [1:0] mode_s2;
		logic [1:0] ja_s1;
		logic [1:0] ja_s2;
		logic [1:0] cod_s;
		logic [1:0] flav_s;
		logic [1:0] mux_s;
		logic [9:0] mon_s;
		logic [2*NUM_CH-1:0] ubs_s;
		logic [2*NUM_CH-1:0] lb_s;
		logic [2*NUM_CH-1:0] mark_s;
		logic [NUM_CH-1:0] mark_d;
		e1m_rst_t   rst_st;
		logic [15:0] rst_cnt;
		e1m_ctl_t   ctl;
		logic       par_en;
		logic       ser_en;
		logic       sep_strobe;
		logic       muxed;
		logic       addr_en;
		logic [NUM_CH-1:0] ami;
		e1m_ja_t    ja;
		e1m_mon_t   mon_kind;
		logic [2:0] mon_ch;
		logic       mon_blk;
		logic       regs_rst;
	} e1m_st_t;
	e1m_st_t st_reg;
	e1m_st_t st_next;
	logic [NUM_CH-1:0] los_w;
	logic [NUM_CH-1:0] mark_edge_w;

	function automatic e1m_ctl_t dec_ctl(input logic [1:0] t);
		case (t)
			`E1M_TRI_LOW:  dec_ctl = E1M_CTL_HW;
			`E1M_TRI_HIGH: dec_ctl = E1M_CTL_PAR;
			default:       dec_ctl = E1M_CTL_SER;
		endcase
	endfunction

	function automatic e1m_ja_t dec_ja(input logic [1:0] t);
		case (t)
			`E1M_TRI_LOW:  dec_ja = E1M_JA_TX;
			`E1M_TRI_HIGH: dec_ja = E1M_JA_RX;
			default:       dec_ja = E1M_JA_OFF;
		endcase
	endfunction

	always_comb begin
		logic [4:0] sel;
		logic       host;
		logic       loop;
		st_next = st_reg;
		sel = '0;
		host = 1'b0;
		loop = 1'b0;
		st_next.mode_s1 = mode_tri_i;
		st_next.mode_s2 = st_reg.mode_s1;
		st_next.ja_s1   = jitter_atten_position_select_i;
		st_next.ja_s2   = st_reg.ja_s1;
		st_next.cod_s   = {st_reg.cod_s[0], codec_select_i};
		st_next.flav_s  = {st_reg.flav_s[0], host_bus_flavour_select_i};
		st_next.mux_s   = {st_reg.mux_s[0], bus_mux_select_i};
		st_next.mon_s   = {st_reg.mon_s[4:0], monitor_select_i};
		st_next.ubs_s   = {st_reg.ubs_s[NUM_CH-1:0], unipolar_bipolar_select_i};
		st_next.lb_s    = {st_reg.lb_s[NUM_CH-1:0], analog_loopback_i};
		st_next.mark_s  = {st_reg.mark_s[NUM_CH-1:0], rx_mark_i};
		st_next.mark_d  = st_reg.mark_s[2*NUM_CH-1:NUM_CH];
		st_next.ctl = dec_ctl(st_reg.mode_s2);
		host = (st_next.ctl != E1M_CTL_HW);
		st_next.par_en  = (st_next.ctl == E1M_CTL_PAR);
		st_next.ser_en  = (st_next.ctl == E1M_CTL_SER);
		st_next.sep_strobe = host && st_reg.flav_s[1];
		st_next.muxed   = st_next.par_en && st_reg.mux_s[1];
		st_next.addr_en = st_next.par_en && !st_reg.mux_s[1];
		st_next.ja = host ? E1M_JA_OFF : dec_ja(st_reg.ja_s2);
		for (int i = 0; i < NUM_CH; i++) begin
			if (host) begin
				st_next.ami[i] = reg_codec_ami_i;
			end else if (st_reg.ubs_s[NUM_CH+i]) begin
				st_next.ami[i] = st_reg.cod_s[1];
			end else begin
				st_next.ami[i] = `E1M_CODEC_HDB3;
			end
		end
		if (host) begin
			sel = reg_monitor_select_i;
		end else begin
			sel = {1'b0, st_reg.mon_s[8:5]};
		end
		st_next.mon_ch = sel[2:0];
		st_next.mon_blk = 1'b0;
		if (sel[2:0] == 3'h0) begin
			st_next.mon_kind = E1M_MON_NONE;
		end else if (!sel[3]) begin
			st_next.mon_kind = E1M_MON_RX;
		end else begin
			loop = st_reg.lb_s[NUM_CH + 32'(sel[2:0])];
			st_next.mon_kind = loop ? E1M_MON_NONE : E1M_MON_TX;
			st_next.mon_blk = loop;
		end
		case (st_reg.rst_st)
			E1M_RS_IDLE: begin
				st_next.regs_rst = 1'b0;
				if (soft_reset_register_wr_i) begin
					st_next.rst_st = E1M_RS_BUSY;
					st_next.regs_rst = 1'b1;
					if (st_reg.par_en && !st_reg.muxed && st_reg.sep_strobe) begin
						st_next.rst_cnt = 16'(RST_LONG_CYC - 1);
					end else begin
						st_next.rst_cnt = 16'(RST_SHORT_CYC - 1);
					end
				end
			end
			E1M_RS_BUSY: begin
				if (st_reg.rst_cnt == 16'h0000) begin
					st_next.rst_st = E1M_RS_IDLE;
					st_next.regs_rst = 1'b0;
				end else begin
					st_next.rst_cnt = st_reg.rst_cnt - 16'h0001;
				end
			end
			default: begin
				st_next.rst_st = E1M_RS_IDLE;
				st_next.regs_rst = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign mark_edge_w = st_reg.mark_s[2*NUM_CH-1:NUM_CH] ^ st_reg.mark_d;

	for (genvar g = 0; g < NUM_CH; g++) begin : g_los
		e1m_los_det #(
			.SET_CYC   (LOS_SET_CYC),
			.WIN_CYC   (LOS_WIN_CYC),
			.CLR_MARKS (LOS_CLR_MARKS)
		) u_los (
			.clk_i     (clk_i),
			.reset_n_i (reset_n_i),
			.clear_i   (st_reg.regs_rst),
			.mark_i    (mark_edge_w[g]),
			.loss_o    (los_w[g])
		);
	end

	assign ctl_mode_o         = st_reg.ctl;
	assign parallel_port_en_o = st_reg.par_en;
	assign serial_port_en_o   = st_reg.ser_en;
	assign sep_strobe_style_o = st_reg.sep_strobe;
	assign muxed_bus_o        = st_reg.muxed;
	assign address_pins_en_o  = st_reg.addr_en;
	assign codec_ami_o        = st_reg.ami;
	assign ja_position_o      = st_reg.ja;
	assign mon_kind_o         = st_reg.mon_kind;
	assign mon_channel_o      = st_reg.mon_ch;
	assign mon_blocked_o      = st_reg.mon_blk;
	assign regs_reset_o       = st_reg.regs_rst;
	assign signal_loss_flag_o = los_w;
endmodule

//--- logic/e1m_consts.svh
`ifndef E1M_CONSTS_SVH
`define E1M_CONSTS_SVH
`define E1M_NUM_CH              8
`define E1M_MON_SEL_W           5
`define E1M_CLK_MHZ             200
`define E1M_RST_LONG_US         2
`define E1M_RST_SHORT_US        1
`define E1M_RST_LONG_CYC        (`E1M_RST_LONG_US * `E1M_CLK_MHZ)
`define E1M_RST_SHORT_CYC       (`E1M_RST_SHORT_US * `E1M_CLK_MHZ)
`define E1M_LOS_SET_CYC         32
`define E1M_LOS_WIN_CYC         64
`define E1M_LOS_CLR_MARKS       12
`define E1M_TRI_LOW             2'h0
`define E1M_TRI_HIGH            2'h1
`define E1M_TRI_MID             2'h2
`define E1M_CODEC_HDB3          1'h0
`define E1M_CODEC_AMI           1'h1
`endif

//--- logic/e1m_pkg.sv
package e1m_pkg;
	typedef enum logic [1:0] {E1M_CTL_HW, E1M_CTL_PAR, E1M_CTL_SER} e1m_ctl_t;
	typedef enum logic [1:0] {E1M_JA_TX, E1M_JA_RX, E1M_JA_OFF} e1m_ja_t;
	typedef enum logic [1:0] {E1M_MON_NONE, E1M_MON_RX, E1M_MON_TX} e1m_mon_t;
	typedef enum logic {E1M_RS_IDLE, E1M_RS_BUSY} e1m_rst_t;
endpackage

//--- logic/e1m_los_det.sv
`timescale 1ns/1ps
`include "e1m_consts.svh"
module e1m_los_det
	import e1m_pkg::*;
#(
	parameter int SET_CYC   = `E1M_LOS_SET_CYC,
	parameter int WIN_CYC   = `E1M_LOS_WIN_CYC,
	parameter int CLR_MARKS = `E1M_LOS_CLR_MARKS
) (
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic clear_i,
	input  wire logic mark_i,
	output logic      loss_o
);
	typedef struct packed {
		logic [15:0] quiet;
		logic [15:0] win;
		logic [15:0] marks;
		logic        loss;
	} e1m_los_st_t;
	e1m_los_st_t st_reg;
	e1m_los_st_t st_next;
	always_comb begin
		st_next = st_reg;
		if (clear_i) begin
			st_next = '0;
		end else if (!st_reg.loss) begin
			if (mark_i) begin
				st_next.quiet = '0;
			end else if (st_reg.quiet >= 16'(SET_CYC - 1)) begin
				st_next.loss  = 1'b1;
				st_next.quiet = '0;
				st_next.win   = '0;
				st_next.marks = '0;
			end else begin
				st_next.quiet = st_reg.quiet + 16'h0001;
			end
		end else begin
			if (st_reg.win >= 16'(WIN_CYC - 1)) begin
				st_next.win   = '0;
				st_next.marks = '0;
			end else begin
				st_next.win = st_reg.win + 16'h0001;
				if (mark_i) begin
					st_next.marks = st_reg.marks + 16'h0001;
				end
			end
			if (mark_i && st_reg.marks >= 16'(CLR_MARKS - 1)) begin
				st_next.loss  = 1'b0;
				st_next.win   = '0;
				st_next.marks = '0;
			end
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign loss_o = st_reg.loss;
endmodule

//--- verification/e1m_chk.sv
`timescale 1ns/1ps
`include "e1m_consts.svh"
module e1m_chk
	import e1m_pkg::*;
#(
	parameter int RST_LONG_CYC  = `E1M_RST_LONG_CYC,
	parameter int RST_SHORT_CYC = `E1M_RST_SHORT_CYC
) (
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	input wire logic       soft_reset_register_wr_i,
	input wire logic [1:0] ctl_mode_o,
	input wire logic       parallel_port_en_o,
	input wire logic       serial_port_en_o,
	input wire logic       sep_strobe_style_o,
	input wire logic       muxed_bus_o,
	input wire logic       address_pins_en_o,
	input wire logic [1:0] ja_position_o,
	input wire logic [1:0] mon_kind_o,
	input wire logic [2:0] mon_channel_o,
	input wire logic       mon_blocked_o,
	input wire logic       regs_reset_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	int unsigned rst_cnt;
	always_ff @(posedge clk_i or negedge reset_n_i)
		if (!reset_n_i) rst_cnt <= 0;
		else rst_cnt <= regs_reset_o ? rst_cnt + 1 : 0;
	property p_par; ctl_mode_o == 2'h1 |-> parallel_port_en_o && !serial_port_en_o; endproperty
	a_par: assert property (p_par) else $error("parallel mode port enables wrong");
	property p_ser; serial_port_en_o |-> ctl_mode_o == 2'h2 && !parallel_port_en_o; endproperty
	a_ser: assert property (p_ser) else $error("serial port enabled outside serial mode");
	property p_hw; ctl_mode_o == 2'h0 |-> !parallel_port_en_o && !sep_strobe_style_o; endproperty
	a_hw: assert property (p_hw) else $error("host port active in hardware mode");
	property p_ja; ctl_mode_o != 2'h0 |-> ja_position_o == 2'h2; endproperty
	a_ja: assert property (p_ja) else $error("attenuator placed in host mode");
	property p_mux; muxed_bus_o |-> parallel_port_en_o && !address_pins_en_o; endproperty
	a_mux: assert property (p_mux) else $error("bus form inconsistent");
	property p_addr; address_pins_en_o |-> ctl_mode_o == 2'h1 && !muxed_bus_o; endproperty
	a_addr: assert property (p_addr) else $error("address pins outside parallel mode");
	property p_blk; mon_blocked_o |-> mon_kind_o == 2'h0; endproperty
	a_blk: assert property (p_blk) else $error("blocked monitor still active");
	property p_rx; mon_kind_o == 2'h1 |-> mon_channel_o != 3'h0; endproperty
	a_rx: assert property (p_rx) else $error("receiver monitor on channel zero");
	property p_rst_go; soft_reset_register_wr_i && !regs_reset_o |=> regs_reset_o; endproperty
	a_rst_go: assert property (p_rst_go) else $error("soft reset did not start");
	property p_rst_len;
		$fell(regs_reset_o) |-> rst_cnt == RST_SHORT_CYC || rst_cnt == RST_LONG_CYC;
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("soft reset length wrong");
endmodule
bind e1m_mode_decode e1m_chk #(.RST_LONG_CYC(RST_LONG_CYC), .RST_SHORT_CYC(RST_SHORT_CYC)) u_chk (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .soft_reset_register_wr_i(soft_reset_register_wr_i),
	.ctl_mode_o(ctl_mode_o), .parallel_port_en_o(parallel_port_en_o),
	.serial_port_en_o(serial_port_en_o), .sep_strobe_style_o(sep_strobe_style_o),
	.muxed_bus_o(muxed_bus_o), .address_pins_en_o(address_pins_en_o),
	.ja_position_o(ja_position_o), .mon_kind_o(mon_kind_o), .mon_channel_o(mon_channel_o),
	.mon_blocked_o(mon_blocked_o), .regs_reset_o(regs_reset_o));

//--- verification/e1m_board.sv
`timescale 1ns/1ps
module e1m_board (
	input  wire logic       clk_i,
	input  wire logic       hw_mode_i,
	input  wire logic [4:0] pin_sel_i,
	input  wire logic [7:0] mark_en_i,
	input  wire logic       host_wr_i,
	output logic      [4:0] monitor_select_o,
	output logic      [7:0] rx_mark_o,
	output logic            soft_reset_register_wr_o
);
	logic host_cs_n;
	// chip select low for the whole host write access
	assign host_cs_n = ~host_wr_i;
	assign soft_reset_register_wr_o = host_wr_i & ~host_cs_n;
	// top monitor pin grounded on the board in hardware mode
	assign monitor_select_o = {pin_sel_i[4] & ~hw_mode_i, pin_sel_i[3:0]};
	initial rx_mark_o = 8'h00;
	always @(posedge clk_i) rx_mark_o <= rx_mark_o ^ mark_en_i;
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	import e1m_pkg::*;
	logic       clk = 0, rst_n = 0, sw = 0, rcod = 0, cod = 0, flv = 0, mx = 0;
	logic [1:0] md = 0, ja = 0, ctl, jap, mk_o;
	logic [4:0] psel = 0, rmon = 0, msel;
	logic [7:0] unipolar_bipolar_select = 0, lb = 0, men = 0, mk, ami, los;
	logic [2:0] mch;
	logic       ppe, spe, sst, mxo, ape, mbl, rr, wr;
	int         n_fail = 0, num_checks = 0;
	always #2.5 clk = ~clk;
	e1m_board u_board (.clk_i(clk), .hw_mode_i(md == 2'h0), .pin_sel_i(psel), .mark_en_i(men),
		.host_wr_i(sw), .monitor_select_o(msel), .rx_mark_o(mk),
		.soft_reset_register_wr_o(wr));
	e1m_mode_decode #(.RST_LONG_CYC(8), .RST_SHORT_CYC(4), .LOS_SET_CYC(8), .LOS_WIN_CYC(16),
		.LOS_CLR_MARKS(4)) DUT (.clk_i(clk), .reset_n_i(rst_n), .mode_tri_i(md),
		.jitter_atten_position_select_i(ja), .codec_select_i(cod), .host_bus_flavour_select_i(flv),
		.bus_mux_select_i(mx), .monitor_select_i(msel), .unipolar_bipolar_select_i(unipolar_bipolar_select),
		.analog_loopback_i(lb), .reg_codec_ami_i(rcod), .reg_monitor_select_i(rmon),
		.soft_reset_register_wr_i(wr), .rx_mark_i(mk), .ctl_mode_o(ctl),
		.parallel_port_en_o(ppe), .serial_port_en_o(spe), .sep_strobe_style_o(sst),
		.muxed_bus_o(mxo), .address_pins_en_o(ape), .codec_ami_o(ami), .ja_position_o(jap),
		.mon_kind_o(mk_o), .mon_channel_o(mch), .mon_blocked_o(mbl), .regs_reset_o(rr),
		.signal_loss_flag_o(los));
	task automatic report_and_stop;
		if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_all;
		int c, n;
		logic [4:0] s;
		c = (md > 1) ? 2 : md;
		chk(ctl, c);
		chk(ppe, c == 1);
		chk(spe, c == 2);
		chk(sst, c != 0 && flv);
		chk(mxo, c == 1 && mx);
		chk(ape, c == 1 && !mx);
		chk(ami, c != 0 ? {8{rcod}} : (unipolar_bipolar_select & {8{cod}}));
		chk(jap, c != 0 ? 2 : (ja > 1 ? 2 : ja));
		chk(los, 8'hA5);
		s = (c == 0) ? {1'b0, msel[3:0]} : rmon;
		n = s[2:0];
		if (n == 0) begin
			chk(mk_o, 0);
			chk(mbl, 0);
		end else if (!s[3]) begin
			chk(mk_o, 1);
			chk(mch, n);
			chk(mbl, 0);
		end else begin
			chk(mk_o, lb[n] ? 0 : 2);
			chk(mch, n);
			chk(mbl, lb[n]);
		end
	endtask
	task automatic soft_rst(input logic [1:0] m, input logic x, input int len);
		int k;
		@(posedge clk);
		md <= m;
		flv <= 1;
		mx <= x;
		repeat (6) @(posedge clk);
		sw <= 1;
		@(posedge clk);
		sw <= 0;
		k = 0;
		for (int i = 0; i < 30; i++) begin
			#1 if (rr === 1'b1) k++;
			if (i == 2) chk(los, 8'h00);
			if (i == 29) chk(los, 8'hA5);
			@(posedge clk);
		end
		chk(k, len);
	endtask
	initial begin
		void'($urandom(78293));
		repeat (10) @(posedge clk);
		rst_n <= 1;
		repeat (20) @(posedge clk);
		#1 chk(los, 8'hFF);
		@(posedge clk);
		men <= 8'h5A;
		repeat (40) @(posedge clk);
		#1 chk(los, 8'hA5);
		repeat (60) begin
			@(posedge clk);
			md <= 2'($urandom);
			ja <= 2'($urandom);
			{cod, flv, mx, rcod} <= 4'($urandom);
			psel <= 5'($urandom);
			rmon <= 5'($urandom);
			unipolar_bipolar_select <= 8'($urandom);
			lb <= 8'($urandom);
			repeat (6) @(posedge clk);
			#1 check_all;
		end
		soft_rst(2'h1, 1'b0, 8);
		soft_rst(2'h1, 1'b1, 4);
		soft_rst(2'h0, 1'b0, 4);
		soft_rst(2'h2, 1'b0, 4);
		report_and_stop;
	end
	initial begin
		#20000;
		n_fail++;
		report_and_stop;
	end
endmodule
